// File: design/kpi_pkg.sv
// kpi_pkg: constants and carrier types for the key wake unit.
// assumes a 32-bit apb slave on pclk and eight pin inputs.
package kpi_pkg;

   // ----------------------------------------------------------------
   // geometry
   // ----------------------------------------------------------------
   localparam int          KPI_PINS   = 8;
   localparam int          KPI_ADDR_W = 12;
   localparam int          KPI_DATA_W = 32;

   // ----------------------------------------------------------------
   // register byte offsets
   // ----------------------------------------------------------------
   localparam logic [11:0] KPI_OFS_STATUS_CONTROL = 12'h000;
   localparam logic [11:0] KPI_OFS_PIN_SELECT     = 12'h004;
   localparam logic [11:0] KPI_OFS_POLARITY       = 12'h008;
   localparam logic [11:0] KPI_OFS_PULL_ENABLE    = 12'h00c;

   // ----------------------------------------------------------------
   // status_control_register field positions
   // ----------------------------------------------------------------
   localparam int          KPI_SC_MODE_BIT  = 0;
   localparam int          KPI_SC_IRQEN_BIT = 1;
   localparam int          KPI_SC_ACK_BIT   = 2;
   localparam int          KPI_SC_FLAG_BIT  = 3;

   // ----------------------------------------------------------------
   // reset values
   // ----------------------------------------------------------------
   localparam logic        KPI_RST_MODE    = 1'b0;
   localparam logic        KPI_RST_IRQEN   = 1'b0;
   localparam logic        KPI_RST_FLAG    = 1'b0;
   localparam logic [7:0]  KPI_RST_PINSEL  = 8'h00;
   localparam logic [7:0]  KPI_RST_POL     = 8'h00;
   localparam logic [7:0]  KPI_RST_PULL    = 8'h00;
   localparam logic [7:0]  KPI_RST_SAMPLE  = 8'h00;

   // ----------------------------------------------------------------
   // timing: flops between a pin and the detector
   // ----------------------------------------------------------------
   localparam int          KPI_SYNC_STAGES = 2;

   // ----------------------------------------------------------------
   // types
   // ----------------------------------------------------------------
   typedef enum logic {
      KPI_EDGE_ONLY  = 1'b0,
      KPI_EDGE_LEVEL = 1'b1
   } kpi_mode_t;

   // configuration handed to the pin detector
   typedef struct packed {
      logic [7:0] pin_select_bit;
      logic [7:0] polarity_bit;
   } kpi_cfg_t;

   // per-pin detector results
   typedef struct packed {
      logic [7:0] edge_hit;
      logic [7:0] level_hit;
   } kpi_pin_evt_t;

endpackage : kpi_pkg

// File: design/kpi_pin_detect.sv
// kpi_pin_detect: per-pin synchroniser, edge and level detection.
// assumes pins are asynchronous to pclk; config comes from pclk logic.
`timescale 1ns/1ps
`default_nettype none

module kpi_pin_detect
   import kpi_pkg::*;
(
   // clock and reset
   input  wire logic         pclk,
   input  wire logic         presetn,
   // raw pins and configuration
   input  wire logic [7:0]   pin_in,
   input  wire kpi_cfg_t     cfg,
   // detector results
   output kpi_pin_evt_t      evt
);

   // per-pin results gather on nets, so each bit has its own driver
   wire logic [KPI_PINS-1:0] edge_w;
   wire logic [KPI_PINS-1:0] level_w;

   // ----------------------------------------------------------------
   // per-pin logic
   // ----------------------------------------------------------------
   genvar i;
   generate
      for (i = 0; i < KPI_PINS; i++)
      begin : g_pin
         logic sync1_r;
         logic sync2_r;
         logic prev_r;
         logic now_asserted;
         logic was_asserted;

         // two-flop synchroniser, then one sample of history;
         // only sync2_r reads sync1_r, so a metastable value never reaches logic
         always_ff @(posedge pclk or negedge presetn)
         begin
            if (!presetn)
            begin
               sync1_r <= KPI_RST_SAMPLE[i];
               sync2_r <= KPI_RST_SAMPLE[i];
               prev_r  <= KPI_RST_SAMPLE[i];
            end
            else
            begin
               sync1_r <= pin_in[i];
               sync2_r <= sync1_r;
               prev_r  <= sync2_r;
            end
         end

         // polarity 1 means high is asserted, 0 means low is asserted
         assign now_asserted = sync2_r ~^ cfg.polarity_bit[i];
         assign was_asserted = prev_r ~^ cfg.polarity_bit[i];

         // edge needs the previous sample at the deasserted level
         assign edge_w[i]  = cfg.pin_select_bit[i] & now_asserted
                             & ~was_asserted;
         assign level_w[i] = cfg.pin_select_bit[i] & now_asserted;
      end
   endgenerate

   // one driver for the whole result struct
   assign evt = '{edge_hit: edge_w, level_hit: level_w};

endmodule : kpi_pin_detect

`default_nettype wire

// File: design/kpi_key_wake_unit.sv
// kpi_key_wake_unit: key wake unit with apb register access.
// assumes a single pclk domain; pins arrive asynchronously.
//
// Chosen here: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none

module kpi_key_wake_unit
   import kpi_pkg::*;
(
   // clock and reset
   input  wire logic                  pclk,
   input  wire logic                  presetn,
   // apb slave
   input  wire logic                  psel,
   input  wire logic                  penable,
   input  wire logic                  pwrite,
   input  wire logic [KPI_ADDR_W-1:0] paddr,
   input  wire logic [KPI_DATA_W-1:0] pwdata,
   output logic      [KPI_DATA_W-1:0] prdata,
   output logic                       pready,
   output logic                       pslverr,
   // keyboard pins
   input  wire logic [KPI_PINS-1:0]   key_pin_in,
   // pull resistor control toward the port pads
   output logic      [KPI_PINS-1:0]   pull_enable_out,
   output logic      [KPI_PINS-1:0]   pull_down_sel,
   // interrupt request to the processor
   output logic                       irq_request
);

   // ----------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------
   kpi_mode_t    detect_mode_sel_r;
   logic         irq_request_enable_r;
   logic         pin_event_flag_r;
   logic [7:0]   pin_select_register_r;
   logic [7:0]   polarity_register_r;
   logic [7:0]   pull_enable_r;
   logic [31:0]  prdata_r;

   kpi_cfg_t     det_cfg;
   kpi_pin_evt_t det_evt;

   logic         setup_phase;
   logic         access_phase;
   logic         wr_strobe;
   logic         addr_hit;
   logic         hit_sc;
   logic         hit_pe;
   logic         hit_pol;
   logic         hit_pull;
   logic         ack_write;
   logic         edge_any;
   logic         level_any;
   logic         set_event;
   logic         pin_event_flag_nxt;
   logic [31:0]  read_word_nxt;

   // ----------------------------------------------------------------
   // apb decode
   // ----------------------------------------------------------------

   // the slave never waits, so a transfer always ends one access cycle in
   assign setup_phase  = psel & ~penable;
   assign access_phase = psel & penable;
   assign hit_sc       = (paddr == KPI_OFS_STATUS_CONTROL);
   assign hit_pe       = (paddr == KPI_OFS_PIN_SELECT);
   assign hit_pol      = (paddr == KPI_OFS_POLARITY);
   assign hit_pull     = (paddr == KPI_OFS_PULL_ENABLE);
   assign addr_hit     = hit_sc | hit_pe | hit_pol | hit_pull;
   assign wr_strobe    = access_phase & pwrite & addr_hit;

   // handshake is combinational; unmapped addresses answer with an error
   assign pready  = 1'b1;
   assign pslverr = access_phase & ~addr_hit;

   // ----------------------------------------------------------------
   // configuration registers
   // ----------------------------------------------------------------

   // mode and interrupt enable live in the status/control word
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         detect_mode_sel_r    <= kpi_mode_t'(KPI_RST_MODE);
         irq_request_enable_r <= KPI_RST_IRQEN;
      end
      else if (wr_strobe && hit_sc)
      begin
         detect_mode_sel_r    <= kpi_mode_t'(pwdata[KPI_SC_MODE_BIT]);
         irq_request_enable_r <= pwdata[KPI_SC_IRQEN_BIT];
      end
   end

   // one select bit per pin
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pin_select_register_r <= KPI_RST_PINSEL;
      end
      else if (wr_strobe && hit_pe)
      begin
         pin_select_register_r <= pwdata[7:0];
      end
   end

   // one polarity bit per pin, also picks the pull direction
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         polarity_register_r <= KPI_RST_POL;
      end
      else if (wr_strobe && hit_pol)
      begin
         polarity_register_r <= pwdata[7:0];
      end
   end

   // pull enables sit here so the block can steer its own pads
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pull_enable_r <= KPI_RST_PULL;
      end
      else if (wr_strobe && hit_pull)
      begin
         pull_enable_r <= pwdata[7:0];
      end
   end

   // pull direction follows polarity: 0 pull-up, 1 pull-down
   assign pull_enable_out = pull_enable_r;
   assign pull_down_sel   = pull_enable_r & polarity_register_r;

   // ----------------------------------------------------------------
   // pin detection
   // ----------------------------------------------------------------
   assign det_cfg = '{pin_select_bit: pin_select_register_r, polarity_bit: polarity_register_r};

   kpi_pin_detect i_kpi_pin_detect (
      .pclk    (pclk),
      .presetn (presetn),
      .pin_in  (key_pin_in),
      .cfg     (det_cfg),
      .evt     (det_evt)
   );

   // all eight pins fold into one event source
   assign edge_any  = |det_evt.edge_hit;
   assign level_any = |det_evt.level_hit;

   // level only counts in edge-and-level mode
   assign set_event = edge_any
                    | ((detect_mode_sel_r == KPI_EDGE_LEVEL) & level_any);

   // ----------------------------------------------------------------
   // event flag
   // ----------------------------------------------------------------

   // a write with the ack bit set is the only clearing path
   assign ack_write = wr_strobe & hit_sc & pwdata[KPI_SC_ACK_BIT];

   // set wins over clear; in level mode a held level also re-sets the
   // flag, which is what keeps an ack from clearing an asserted pin.
   // the first enable of a pin may set it falsely; software acks it.
   always_comb
   begin
      pin_event_flag_nxt = pin_event_flag_r;
      if (ack_write)
      begin
         pin_event_flag_nxt = 1'b0;
      end
      if (set_event)
      begin
         pin_event_flag_nxt = 1'b1;
      end
   end

   // pwdata at the flag position is never looked at
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pin_event_flag_r <= KPI_RST_FLAG;
      end
      else
      begin
         pin_event_flag_r <= pin_event_flag_nxt;
      end
   end

   // request is a plain level while flag and enable are both set
   assign irq_request = pin_event_flag_r & irq_request_enable_r;

   // ----------------------------------------------------------------
   // read path
   // ----------------------------------------------------------------

   // read word chosen during setup; the flag seen is the setup-cycle one
   always_comb
   begin
      read_word_nxt = 32'h0000_0000;
      if (hit_sc)
      begin
         read_word_nxt[KPI_SC_MODE_BIT]  = detect_mode_sel_r;
         read_word_nxt[KPI_SC_IRQEN_BIT] = irq_request_enable_r;
         read_word_nxt[KPI_SC_ACK_BIT]   = 1'b0;
         read_word_nxt[KPI_SC_FLAG_BIT]  = pin_event_flag_r;
      end
      else if (hit_pe)
      begin
         read_word_nxt[7:0] = pin_select_register_r;
      end
      else if (hit_pol)
      begin
         read_word_nxt[7:0] = polarity_register_r;
      end
      else if (hit_pull)
      begin
         read_word_nxt[7:0] = pull_enable_r;
      end
   end

   // capture in setup so prdata comes from a flop in the access cycle
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata_r <= 32'h0000_0000;
      end
      else if (setup_phase && !pwrite)
      begin
         prdata_r <= read_word_nxt;
      end
   end

   assign prdata = prdata_r;

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   // an edge always shows in the flag one cycle later
   a_edge_sets_flag: assert property (
      edge_any |=> pin_event_flag_r)
      else $error("edge did not set the event flag");

   // a held level in level mode keeps the flag set over two cycles
   a_level_sets_flag: assert property (
      ((detect_mode_sel_r == KPI_EDGE_LEVEL) && level_any) [*2]
      |=> pin_event_flag_r)
      else $error("asserted level did not hold the flag");

   // levels alone do nothing in edge-only mode
   a_edge_mode_level: assert property (
      (detect_mode_sel_r == KPI_EDGE_ONLY) && !edge_any && !pin_event_flag_r
      |=> !pin_event_flag_r)
      else $error("flag set without an edge in edge-only mode");

   // request tracks the flag while enabled
   a_irq_on_flag: assert property (
      irq_request_enable_r && $rose(pin_event_flag_r)
      |-> irq_request ##0 $past(set_event))
      else $error("flag rose without request or cause");

   // ack with nothing pending clears the flag
   a_ack_clears: assert property (
      ack_write && !set_event |=> !pin_event_flag_r && !irq_request)
      else $error("ack did not clear the flag");

   // ack during an asserted enabled level is ignored in level mode
   a_level_blocks_ack: assert property (
      ack_write && (detect_mode_sel_r == KPI_EDGE_LEVEL) && level_any
      |=> pin_event_flag_r)
      else $error("ack cleared flag while a pin was asserted");

   // status reads never show the ack bit
   a_ack_reads_zero: assert property (
      setup_phase && !pwrite && hit_sc
      |=> !prdata[KPI_SC_ACK_BIT]
          && (prdata[KPI_SC_FLAG_BIT] == $past(pin_event_flag_r)))
      else $error("status read shows ack bit or stale flag");

   // writing a 1 to the flag position alone cannot set the flag
   a_flag_write_ignored: assert property (
      wr_strobe && hit_sc && !pin_event_flag_r && !set_event
      |=> !pin_event_flag_r)
      else $error("write to flag position changed the flag");

   // with no pin selected nothing is detected
   a_disabled_pins: assert property (
      pin_select_register_r == 8'h00 |-> !edge_any && !level_any)
      else $error("detection with no pin selected");

   // a pin change needs the synchroniser before it can count: an edge on
   // pin 0 must show the asserted level at the pin two samples earlier
   a_sync_latency: assert property (
      $rose(det_evt.edge_hit[0]) |-> $past(key_pin_in[0] ~^ polarity_register_r[0], 2))
      else $error("edge seen too soon after pin change");

   // pull-down only with pull enabled and polarity 1
   a_pull_select: assert property (
      (pull_down_sel & ~polarity_register_r) == 8'h00
      && (pull_down_sel & ~pull_enable_out) == 8'h00)
      else $error("pull direction disagrees with polarity");

   // only an ack write can take a set flag down
   a_flag_holds: assert property (
      pin_event_flag_r && !ack_write |=> pin_event_flag_r)
      else $error("flag dropped without an ack");

   // a pin select write lands in the register at its access edge
   a_write_lands: assert property (
      wr_strobe && hit_pe |=> pin_select_register_r == $past(pwdata[7:0]))
      else $error("pin select write did not land");

endmodule : kpi_key_wake_unit

`default_nettype wire

// File: verification/kpi_key_model.sv
// kpi_key_model: behavioural keys and external sources on the eight pins.
// assumes the bench sets press enables and levels; pull controls come from the dut pads.
`timescale 1ns/1ps
`default_nettype none

module kpi_key_model
   import kpi_pkg::*;
(
   // clock and reset
   input  wire logic                pclk,
   input  wire logic                presetn,
   // bench control
   input  wire logic [KPI_PINS-1:0] press_en,
   input  wire logic [KPI_PINS-1:0] press_val,
   // pad controls from the dut
   input  wire logic [KPI_PINS-1:0] pull_en,
   input  wire logic [KPI_PINS-1:0] pull_dn,
   // pins toward the dut
   output logic      [KPI_PINS-1:0] key_pin
);

   logic [KPI_PINS-1:0] float_r;

   // a floating pin changes every cycle, so no stale level is ever trusted
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         float_r <= 8'h55;
      else
         float_r <= ~float_r;
   end

   // a pressed key wins; a released one sits at its pull level or floats
   always_comb
   begin
      for (int i = 0; i < KPI_PINS; i++)
      begin
         if (press_en[i])
            key_pin[i] = press_val[i];
         else if (pull_en[i])
            key_pin[i] = ~pull_dn[i];
         else
            key_pin[i] = float_r[i];
      end
   end

endmodule : kpi_key_model

`default_nettype wire

// File: verification/keyboard_pin_interrupt_tb_top.sv
// keyboard_pin_interrupt_tb_top: self-checking bench for the key wake unit.
// assumes zero-wait apb answers and a key model on the pins; one 50 MHz clock.
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, exp, got) begin tests_run++; if ((got) !== (exp)) begin err_total++; \
   $display("CHECK FAILED %s expected %h seen %h", nm, exp, got); end end

module keyboard_pin_interrupt_tb_top;
   import kpi_pkg::*;

   // ----------------------------------------------------------------
   // signals
   // ----------------------------------------------------------------
   logic                  pclk;
   logic                  presetn;
   logic                  psel;
   logic                  penable;
   logic                  pwrite;
   logic [KPI_ADDR_W-1:0] paddr;
   logic [KPI_DATA_W-1:0] pwdata;
   logic [KPI_DATA_W-1:0] prdata;
   logic                  pready;
   logic                  pslverr;
   logic [KPI_PINS-1:0]   key_pin_in;
   logic [KPI_PINS-1:0]   pull_enable_out;
   logic [KPI_PINS-1:0]   pull_down_sel;
   logic                  irq_request;
   logic [KPI_PINS-1:0]   press_en;
   logic [KPI_PINS-1:0]   press_val;
   int                    err_total;
   int                    tests_run;
   int                    cyc_cnt;
   logic [31:0]           q;
   logic                  e;

   localparam logic [31:0] MODE = 32'h1 << KPI_SC_MODE_BIT;
   localparam logic [31:0] IRQ  = 32'h1 << KPI_SC_IRQEN_BIT;
   localparam logic [31:0] ACK  = 32'h1 << KPI_SC_ACK_BIT;
   localparam logic [31:0] FLG  = 32'h1 << KPI_SC_FLAG_BIT;

   // ----------------------------------------------------------------
   // instances
   // ----------------------------------------------------------------
   kpi_key_wake_unit i_kpi_key_wake_unit (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .key_pin_in(key_pin_in), .pull_enable_out(pull_enable_out), .pull_down_sel(pull_down_sel),
      .irq_request(irq_request));

   kpi_key_model i_kpi_key_model (
      .pclk(pclk), .presetn(presetn), .press_en(press_en), .press_val(press_val),
      .pull_en(pull_enable_out), .pull_dn(pull_down_sel), .key_pin(key_pin_in));

   // clock at 50 MHz
   initial
   begin
      pclk = 1'b0;
      forever #10 pclk = ~pclk;
   end

   // hang guard: the whole sequence needs well under this many cycles
   always @(posedge pclk)
   begin
      cyc_cnt++;
      if (cyc_cnt == 4000)
      begin
         err_total++;
         test_done();
      end
   end

   // ----------------------------------------------------------------
   // bus and helper tasks
   // ----------------------------------------------------------------
   // one apb transfer; holds the request until pready is seen high at an edge
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] rq, output logic er);
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // no assumed wait count; only the bench timeout ends a hang here
      do
      begin
         @(posedge pclk);
      end
      while (pready !== 1'b1);
      rq = prdata;
      er = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d, q, e);
   endtask : wr

   task automatic rd(input logic [11:0] a);
      apb(1'b0, a, 32'h0, q, e);
   endtask : rd

   // set a key; the change lands just after the next edge
   task automatic key(input int i, input logic en, input logic v);
      @(posedge pclk);
      press_en[i]  <= en;
      press_val[i] <= v;
      repeat (5) @(posedge pclk);
   endtask : key

   // masked bring-up in the advised order, ending with a clear flag
   task automatic bring_up(input logic [31:0] mode, input logic [7:0] pol, input logic [7:0] pull,
                           input logic [7:0] sel);
      wr(KPI_OFS_STATUS_CONTROL, mode);
      wr(KPI_OFS_POLARITY, {24'h0, pol});
      wr(KPI_OFS_PULL_ENABLE, {24'h0, pull});
      wr(KPI_OFS_PIN_SELECT, {24'h0, sel});
      repeat (4) @(posedge pclk);
      wr(KPI_OFS_STATUS_CONTROL, mode | ACK);
   endtask : bring_up

   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   // reset values and an unmapped address
   task automatic t_reset();
      `CHK("pready idle", 1'b1, pready)
      rd(KPI_OFS_STATUS_CONTROL);
      `CHK("status reset", 32'h0, q)
      rd(KPI_OFS_PIN_SELECT);
      `CHK("pin select reset", 32'h0, q)
      rd(KPI_OFS_POLARITY);
      `CHK("polarity reset", 32'h0, q)
      rd(KPI_OFS_PULL_ENABLE);
      `CHK("pull reset", 32'h0, q)
      `CHK("irq reset", 1'b0, irq_request)
      rd(12'h010);
      `CHK("unmapped error", 1'b1, e)
      `CHK("unmapped data", 32'h0, q)
   endtask : t_reset

   // falling edge with pull-up; level held low is not an edge after ack
   task automatic t_fall();
      bring_up(32'h0, 8'h00, 8'h01, 8'h01);
      @(negedge pclk);
      `CHK("pull enable", 8'h01, pull_enable_out)
      `CHK("pull-up sel", 8'h00, pull_down_sel)
      rd(KPI_OFS_STATUS_CONTROL);
      `CHK("floating unselected pins", 1'b0, q[KPI_SC_FLAG_BIT])
      key(0, 1'b1, 1'b0);
      rd(KPI_OFS_STATUS_CONTROL);
      `CHK("falling edge flag", 1'b1, q[KPI_SC_FLAG_BIT])
      `CHK("irq masked", 1'b0, irq_request)
      wr(KPI_OFS_STATUS_CONTROL, IRQ);
      @(negedge pclk);
      `CHK("irq raised", 1'b1, irq_request)
      wr(KPI_OFS_STATUS_CONTROL, IRQ | ACK);
      repeat (6) @(posedge pclk);
      rd(KPI_OFS_STATUS_CONTROL);
      `CHK("edge ack, held low", IRQ, q)
      `CHK("irq cleared", 1'b0, irq_request)
      key(0, 1'b0, 1'b0);
      rd(KPI_OFS_STATUS_CONTROL);
      `CHK("release not an edge", 1'b0, q[KPI_SC_FLAG_BIT])
   endtask : t_fall

   // rising edge on pin 1 with pull-down; pin 0 still enabled and idle
   task automatic t_rise();
      bring_up(32'h0, 8'h02, 8'h03, 8'h03);
      @(negedge pclk);
      `CHK("pull-down sel", 8'h02, pull_down_sel)
      key(1, 1'b1, 1'b1);
      rd(KPI_OFS_STATUS_CONTROL);
      `CHK("rising edge flag", 1'b1, q[KPI_SC_FLAG_BIT])
      wr(KPI_OFS_STATUS_CONTROL, ACK);
      key(1, 1'b0, 1'b0);
      wr(KPI_OFS_PIN_SELECT, 32'h0);
      wr(KPI_OFS_STATUS_CONTROL, ACK);
      key(0, 1'b1, 1'b0);
      rd(KPI_OFS_STATUS_CONTROL);
      `CHK("deselected pin ignored", 1'b0, q[KPI_SC_FLAG_BIT])
      key(0, 1'b0, 1'b0);
   endtask : t_rise

   // edge and level: held level blocks ack, release lets it clear
   task automatic t_level();
      bring_up(MODE, 8'h00, 8'h01, 8'h01);
      key(0, 1'b1, 1'b0);
      wr(KPI_OFS_STATUS_CONTROL, MODE | ACK);
      repeat (4) @(posedge pclk);
      rd(KPI_OFS_STATUS_CONTROL);
      `CHK("level keeps flag", MODE | FLG, q)
      key(0, 1'b0, 1'b0);
      wr(KPI_OFS_STATUS_CONTROL, MODE | ACK);
      repeat (4) @(posedge pclk);
      rd(KPI_OFS_STATUS_CONTROL);
      `CHK("level ack clears", MODE, q)
      wr(KPI_OFS_STATUS_CONTROL, MODE | FLG);
      rd(KPI_OFS_STATUS_CONTROL);
      `CHK("flag write ignored", MODE, q)
      wr(KPI_OFS_PIN_SELECT, 32'h0);
      key(0, 1'b1, 1'b0);
      wr(KPI_OFS_PIN_SELECT, 32'h01);
      repeat (4) @(posedge pclk);
      rd(KPI_OFS_STATUS_CONTROL);
      `CHK("held level sets flag", MODE | FLG, q)
      key(0, 1'b0, 1'b0);
   endtask : t_level

   // ----------------------------------------------------------------
   // closing and main sequence
   // ----------------------------------------------------------------
   task automatic test_done();
      $display("checks run %0d, mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : test_done

   initial
   begin
      presetn   = 1'b0;
      psel      = 1'b0;
      penable   = 1'b0;
      pwrite    = 1'b0;
      paddr     = 12'h000;
      pwdata    = 32'h0;
      press_en  = 8'h00;
      press_val = 8'h00;
      err_total = 0;
      tests_run = 0;
      cyc_cnt   = 0;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_fall();
      t_rise();
      t_level();
      test_done();
   end

endmodule : keyboard_pin_interrupt_tb_top

`undef CHK
`default_nettype wire
